// [src/meter_cfg_defs.svh]
/*
 * Register offsets, reset values and scaling shift amounts of the metering configuration bank.
 * Assumes byte addressing with 16-bit words on even addresses and 32-bit words on multiples of four.
 */
`ifndef METER_CFG_DEFS_SVH
`define METER_CFG_DEFS_SVH

`define OFF_SCAN_BASE 7'h10
`define OFF_SCAN1 7'h12
`define OFF_SCAN2 7'h14
`define OFF_SCAN3 7'h16
`define OFF_SCAN4 7'h18
`define OFF_SCAN5 7'h1a
`define OFF_SCAN6 7'h1c
`define OFF_SCAN_LAST 7'h1e
`define OFF_FRAME_TIME 7'h20
`define OFF_VOLT_CAL 7'h22
`define OFF_AMP_CAL 7'h24
`define OFF_PWR_CAL 7'h26
`define OFF_ENERGY_THR 7'h28
`define OFF_AMPHR_THR 7'h2c
`define OFF_CYCLE_CNT 7'h30
`define OFF_PULSE_CFG 7'h32
`define OFF_PULSE1_THR 7'h34
`define OFF_PULSE2_THR 7'h38
`define OFF_PULSE1_WD 7'h3c
`define OFF_PULSE2_WD 7'h3e
`define OFF_ALLPASS0 7'h54
`define OFF_ALLPASS1 7'h56
`define OFF_LPF_ZC 7'h58
`define OFF_LPF_NS 7'h5a
`define OFF_LPF_SM 7'h5c
`define OFF_HPF 7'h5e
`define OFF_BPF_B0 7'h60
`define OFF_BPF_A1 7'h62
`define OFF_PEAK_CYC 7'h6c
`define OFF_SAG_CYC 7'h6e
`define OFF_OC_LVL 7'h70
`define OFF_OV_LVL 7'h72
`define OFF_SAG_LVL 7'h74
`define OFF_IUB_LVL 7'h76
`define OFF_VUB_LVL 7'h78
`define OFF_ZERO_CROSS_TIMEOUT 7'h7a

`define RST_SCAN0 16'h0301
`define RST_SCAN1 16'h0003
`define RST_SCAN2 16'h0505
`define RST_SCAN3 16'h0207
`define RST_SCAN4 16'h0409
`define RST_SCAN5 16'h010b
`define RST_SCAN6 16'h068d
`define RST_SCAN7 16'h08af
`define RST_FRAME_TIME 16'h07d0
`define RST_VOLT_CAL 16'h81f0
`define RST_AMP_CAL 16'h17d8
`define RST_PWR_CAL 16'h3539
`define RST_ENERGY_THR 32'h00841c2f
`define RST_AMPHR_THR 32'h11940000
`define RST_CYCLE_CNT 16'h0001
`define RST_PULSE_CFG 16'h1707
`define RST_PULSE_THR 32'h019cd813
`define RST_PULSE_WD 16'h186a
`define RST_ALLPASS0 16'h3000
`define RST_ALLPASS1 16'h5000
`define RST_LPF_ZC 16'h1000
`define RST_LPF_NS 16'h0800
`define RST_LPF_SM 16'h1000
`define RST_HPF 16'h0200
`define RST_BPF_B0 16'h1000
`define RST_BPF_A1 16'h301a
`define RST_PEAK_CYC 16'h0032
`define RST_SAG_CYC 16'h0005
`define RST_OC_LVL 16'h7fff
`define RST_OV_LVL 16'h7fff
`define RST_SAG_LVL 16'h0000
`define RST_IUB_LVL 16'hffff
`define RST_VUB_LVL 16'hffff
`define RST_ZERO_CROSS_TIMEOUT 16'h0640

`define VOLT_SHIFT 16
`define AMP_SHIFT 16
`define PWR_SHIFT 26

`endif

// [src/meter_cfg_pkg.sv]
/*
 * Types of the metering configuration bank.
 * Assumes the offsets and resets of meter_cfg_defs.svh.
 */
package meter_cfg_pkg;

	typedef logic [2:0] elements_t;

	typedef struct packed {
		logic [3:0] reservedHigh;
		logic [3:0] muxSel;
		logic slotConversionSkip;
		logic [2:0] gainSel;
		logic [2:0] lineQuantitySelect;
		logic reservedLow;
	} scan_slot_t;

	typedef struct packed {
		logic [4:0] pulseTwoSource;
		elements_t pulseTwoElements;
		logic [4:0] pulseOneSource;
		elements_t pulseOneElements;
	} pulse_cfg_t;

	typedef struct packed {
		scan_slot_t [7:0] scanSlot;
		logic [15:0] frameTimeCal;
		logic [15:0] voltageCal;
		logic [15:0] currentCal;
		logic [15:0] powerCal;
		logic [31:0] energyLsbThreshold;
		logic [31:0] amphourLsbThreshold;
		logic [15:0] energyCycleCount;
		pulse_cfg_t pulseCfg;
		logic [31:0] pulseOneThreshold;
		logic [31:0] pulseTwoThreshold;
		logic [15:0] pulseOneWidth;
		logic [15:0] pulseTwoWidth;
		logic [15:0] allpassCoef0;
		logic [15:0] allpassCoef1;
		logic [15:0] lowpassZeroCrossCoef;
		logic [15:0] lowpassPeriodCoef;
		logic [15:0] lowpassSamplesCoef;
		logic [15:0] highpassCoef;
		logic [15:0] bandpassCoefB0;
		logic [15:0] bandpassCoefA1;
		logic [15:0] peakCycleCount;
		logic [15:0] sagCycleCount;
		logic [15:0] overcurrentLevel;
		logic [15:0] overvoltageLevel;
		logic [15:0] sagLevel;
		logic [15:0] currentUnbalanceLevel;
		logic [15:0] voltageUnbalanceLevel;
		logic [15:0] zeroCrossTimeout;
	} cfg_bank_t;

	typedef struct packed {
		logic [15:0] reportedVoltage;
		logic [15:0] reportedCurrent;
		logic [31:0] reportedPower;
	} scaled_t;

	typedef struct packed {
		cfg_bank_t bank;
		logic [31:0] readData;
		logic readHit;
		scaled_t scaled;
	} state_t;

endpackage

// [src/metering_config_register_bank.sv]
/*
 * Configuration word bank of the polyphase metering front-end, with the
 * calibration scaling of reported voltage, current and power.
 * Assumes a serial-interface shadow that presents byte addresses with a
 * write strobe and 16/32-bit word size, and samples readData a cycle later.
 */
`timescale 1ns/1ps
`include "meter_cfg_defs.svh"

// Behaviour
// - slot bits 3:1 pick line quantity
// - frame time word in 0.1us units
// - voltage equals coefficient times rms over 2^16
// - current equals coefficient times rms over 2^16
// - power equals coefficient times i*v over 2^26
// - 32-bit energy accumulator lsb weight
// - 32-bit amp-hour accumulator lsb weight
// - line cycles per energy calculation
// - pulse sources in bits 7:3, 15:11
// - per-pulse element enables E1..E3
// - 32-bit pulse duration thresholds
// - 16-bit pulse width downcounter loads
// - frames before no-zero-crossing declared
// - sag level over sag cycle count
// - peak detection line cycle count
// - frame is rate setting plus one clocks
// - slot bit 7 skips conversion
module metering_config_register_bank
	import meter_cfg_pkg::*;
#(
	parameter int ADDR_W = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register access from the serial shadow
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regWriteData,
	output logic [31:0] readData,
	output logic readHit,
	// measured rms values from the datapath
	input wire logic [15:0] rmsVoltage,
	input wire logic [15:0] rmsCurrent,
	// configuration to the datapath
	output cfg_bank_t cfg,
	output logic [2:0] slotLineQuantity [8],
	output logic [7:0] slotConversionSkip,
	output logic [15:0] frameTimeTenthsUs,
	output logic [4:0] pulseOneSource,
	output elements_t pulseOneElements,
	output logic [4:0] pulseTwoSource,
	output elements_t pulseTwoElements,
	output scaled_t scaled
);

	////////////////////////////////////////////////////////////////////////

	state_t cur;
	state_t next_cur;

	function automatic cfg_bank_t resetBank();
		cfg_bank_t b;
		b.scanSlot[0] = `RST_SCAN0;
		b.scanSlot[1] = `RST_SCAN1;
		b.scanSlot[2] = `RST_SCAN2;
		b.scanSlot[3] = `RST_SCAN3;
		b.scanSlot[4] = `RST_SCAN4;
		b.scanSlot[5] = `RST_SCAN5;
		b.scanSlot[6] = `RST_SCAN6;
		b.scanSlot[7] = `RST_SCAN7;
		b.frameTimeCal = `RST_FRAME_TIME;
		b.voltageCal = `RST_VOLT_CAL;
		b.currentCal = `RST_AMP_CAL;
		b.powerCal = `RST_PWR_CAL;
		b.energyLsbThreshold = `RST_ENERGY_THR;
		b.amphourLsbThreshold = `RST_AMPHR_THR;
		b.energyCycleCount = `RST_CYCLE_CNT;
		b.pulseCfg = `RST_PULSE_CFG;
		b.pulseOneThreshold = `RST_PULSE_THR;
		b.pulseTwoThreshold = `RST_PULSE_THR;
		b.pulseOneWidth = `RST_PULSE_WD;
		b.pulseTwoWidth = `RST_PULSE_WD;
		b.allpassCoef0 = `RST_ALLPASS0;
		b.allpassCoef1 = `RST_ALLPASS1;
		b.lowpassZeroCrossCoef = `RST_LPF_ZC;
		b.lowpassPeriodCoef = `RST_LPF_NS;
		b.lowpassSamplesCoef = `RST_LPF_SM;
		b.highpassCoef = `RST_HPF;
		b.bandpassCoefB0 = `RST_BPF_B0;
		b.bandpassCoefA1 = `RST_BPF_A1;
		b.peakCycleCount = `RST_PEAK_CYC;
		b.sagCycleCount = `RST_SAG_CYC;
		b.overcurrentLevel = `RST_OC_LVL;
		b.overvoltageLevel = `RST_OV_LVL;
		b.sagLevel = `RST_SAG_LVL;
		b.currentUnbalanceLevel = `RST_IUB_LVL;
		b.voltageUnbalanceLevel = `RST_VUB_LVL;
		b.zeroCrossTimeout = `RST_ZERO_CROSS_TIMEOUT;
		return b;
	endfunction

	// coefficient times value, shifted down
	function automatic logic [31:0] scale16(input logic [15:0] coef, input logic [15:0] val);
		logic [31:0] prod;
		prod = coef * val;
		return 32'(prod >> `VOLT_SHIFT);
	endfunction

	////////////////////////////////////////////////////////////////////////

	logic [47:0] powerProduct;
	logic [31:0] ivProduct;

	always_comb begin
		ivProduct = rmsCurrent * rmsVoltage;
		powerProduct = cur.bank.powerCal * ivProduct;
	end

	always_comb begin
		next_cur = cur;
		next_cur.readHit = 1'b0;
		if (regRead) begin
			next_cur.readHit = 1'b1;
			case (regAddr)
				`OFF_SCAN_BASE, `OFF_SCAN1, `OFF_SCAN2, `OFF_SCAN3, `OFF_SCAN4, `OFF_SCAN5, `OFF_SCAN6,
				`OFF_SCAN_LAST:
					next_cur.readData = {16'h0000, cur.bank.scanSlot[regAddr[3:1]]};
				`OFF_FRAME_TIME: next_cur.readData = {16'h0000, cur.bank.frameTimeCal};
				`OFF_VOLT_CAL: next_cur.readData = {16'h0000, cur.bank.voltageCal};
				`OFF_AMP_CAL: next_cur.readData = {16'h0000, cur.bank.currentCal};
				`OFF_PWR_CAL: next_cur.readData = {16'h0000, cur.bank.powerCal};
				`OFF_ENERGY_THR: next_cur.readData = cur.bank.energyLsbThreshold;
				`OFF_AMPHR_THR: next_cur.readData = cur.bank.amphourLsbThreshold;
				`OFF_CYCLE_CNT: next_cur.readData = {16'h0000, cur.bank.energyCycleCount};
				`OFF_PULSE_CFG: next_cur.readData = {16'h0000, cur.bank.pulseCfg};
				`OFF_PULSE1_THR: next_cur.readData = cur.bank.pulseOneThreshold;
				`OFF_PULSE2_THR: next_cur.readData = cur.bank.pulseTwoThreshold;
				`OFF_PULSE1_WD: next_cur.readData = {16'h0000, cur.bank.pulseOneWidth};
				`OFF_PULSE2_WD: next_cur.readData = {16'h0000, cur.bank.pulseTwoWidth};
				`OFF_ALLPASS0: next_cur.readData = {16'h0000, cur.bank.allpassCoef0};
				`OFF_ALLPASS1: next_cur.readData = {16'h0000, cur.bank.allpassCoef1};
				`OFF_LPF_ZC: next_cur.readData = {16'h0000, cur.bank.lowpassZeroCrossCoef};
				`OFF_LPF_NS: next_cur.readData = {16'h0000, cur.bank.lowpassPeriodCoef};
				`OFF_LPF_SM: next_cur.readData = {16'h0000, cur.bank.lowpassSamplesCoef};
				`OFF_HPF: next_cur.readData = {16'h0000, cur.bank.highpassCoef};
				`OFF_BPF_B0: next_cur.readData = {16'h0000, cur.bank.bandpassCoefB0};
				`OFF_BPF_A1: next_cur.readData = {16'h0000, cur.bank.bandpassCoefA1};
				`OFF_PEAK_CYC: next_cur.readData = {16'h0000, cur.bank.peakCycleCount};
				`OFF_SAG_CYC: next_cur.readData = {16'h0000, cur.bank.sagCycleCount};
				`OFF_OC_LVL: next_cur.readData = {16'h0000, cur.bank.overcurrentLevel};
				`OFF_OV_LVL: next_cur.readData = {16'h0000, cur.bank.overvoltageLevel};
				`OFF_SAG_LVL: next_cur.readData = {16'h0000, cur.bank.sagLevel};
				`OFF_IUB_LVL: next_cur.readData = {16'h0000, cur.bank.currentUnbalanceLevel};
				`OFF_VUB_LVL: next_cur.readData = {16'h0000, cur.bank.voltageUnbalanceLevel};
				`OFF_ZERO_CROSS_TIMEOUT: next_cur.readData = {16'h0000, cur.bank.zeroCrossTimeout};
				default: begin
					// unmapped or reserved: zero and no hit
					next_cur.readData = 32'h00000000;
					next_cur.readHit = 1'b0;
				end
			endcase
		end
		if (regWrite) begin
			case (regAddr)
				// slot words hold line quantity and skip
				`OFF_SCAN_BASE, `OFF_SCAN1, `OFF_SCAN2, `OFF_SCAN3, `OFF_SCAN4, `OFF_SCAN5, `OFF_SCAN6,
				`OFF_SCAN_LAST:
					next_cur.bank.scanSlot[regAddr[3:1]] = regWriteData[15:0];
				`OFF_FRAME_TIME: next_cur.bank.frameTimeCal = regWriteData[15:0];
				`OFF_VOLT_CAL: next_cur.bank.voltageCal = regWriteData[15:0];
				`OFF_AMP_CAL: next_cur.bank.currentCal = regWriteData[15:0];
				`OFF_PWR_CAL: next_cur.bank.powerCal = regWriteData[15:0];
				`OFF_ENERGY_THR: next_cur.bank.energyLsbThreshold = regWriteData;
				`OFF_AMPHR_THR: next_cur.bank.amphourLsbThreshold = regWriteData;
				`OFF_CYCLE_CNT: next_cur.bank.energyCycleCount = regWriteData[15:0];
				`OFF_PULSE_CFG: next_cur.bank.pulseCfg = regWriteData[15:0];
				`OFF_PULSE1_THR: next_cur.bank.pulseOneThreshold = regWriteData;
				`OFF_PULSE2_THR: next_cur.bank.pulseTwoThreshold = regWriteData;
				`OFF_PULSE1_WD: next_cur.bank.pulseOneWidth = regWriteData[15:0];
				`OFF_PULSE2_WD: next_cur.bank.pulseTwoWidth = regWriteData[15:0];
				`OFF_ALLPASS0: next_cur.bank.allpassCoef0 = regWriteData[15:0];
				`OFF_ALLPASS1: next_cur.bank.allpassCoef1 = regWriteData[15:0];
				`OFF_LPF_ZC: next_cur.bank.lowpassZeroCrossCoef = regWriteData[15:0];
				`OFF_LPF_NS: next_cur.bank.lowpassPeriodCoef = regWriteData[15:0];
				`OFF_LPF_SM: next_cur.bank.lowpassSamplesCoef = regWriteData[15:0];
				`OFF_HPF: next_cur.bank.highpassCoef = regWriteData[15:0];
				`OFF_BPF_B0: next_cur.bank.bandpassCoefB0 = regWriteData[15:0];
				`OFF_BPF_A1: next_cur.bank.bandpassCoefA1 = regWriteData[15:0];
				`OFF_PEAK_CYC: next_cur.bank.peakCycleCount = regWriteData[15:0];
				`OFF_SAG_CYC: next_cur.bank.sagCycleCount = regWriteData[15:0];
				`OFF_OC_LVL: next_cur.bank.overcurrentLevel = regWriteData[15:0];
				`OFF_OV_LVL: next_cur.bank.overvoltageLevel = regWriteData[15:0];
				`OFF_SAG_LVL: next_cur.bank.sagLevel = regWriteData[15:0];
				`OFF_IUB_LVL: next_cur.bank.currentUnbalanceLevel = regWriteData[15:0];
				`OFF_VUB_LVL: next_cur.bank.voltageUnbalanceLevel = regWriteData[15:0];
				`OFF_ZERO_CROSS_TIMEOUT: next_cur.bank.zeroCrossTimeout = regWriteData[15:0];
				// writes to reserved holes are dropped
				default: next_cur.bank = next_cur.bank;
			endcase
		end
		next_cur.scaled.reportedVoltage = 16'(scale16(cur.bank.voltageCal, rmsVoltage));
		next_cur.scaled.reportedCurrent = 16'(scale16(cur.bank.currentCal, rmsCurrent));
		next_cur.scaled.reportedPower = 32'(powerProduct >> `PWR_SHIFT);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur.bank <= resetBank();
			cur.readData <= 32'h00000000;
			cur.readHit <= 1'b0;
			cur.scaled <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////

	assign cfg = cur.bank;
	assign readData = cur.readData;
	assign readHit = cur.readHit;
	assign scaled = cur.scaled;
	// frame time drives the rate-based timing outside
	assign frameTimeTenthsUs = cur.bank.frameTimeCal;
	assign pulseOneSource = cur.bank.pulseCfg.pulseOneSource;
	assign pulseOneElements = cur.bank.pulseCfg.pulseOneElements;
	assign pulseTwoSource = cur.bank.pulseCfg.pulseTwoSource;
	assign pulseTwoElements = cur.bank.pulseCfg.pulseTwoElements;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			slotLineQuantity[i] = cur.bank.scanSlot[i].lineQuantitySelect;
			slotConversionSkip[i] = cur.bank.scanSlot[i].slotConversionSkip;
		end
	end

endmodule

// [bench/metering_config_register_bank_sva.sv]
/*
 * Port checker of the metering configuration bank, bound to its top module.
 * Assumes one clock, asynchronous active-low reset, one-cycle read answer.
 */
`timescale 1ns/1ps
module metering_config_register_bank_sva
	import meter_cfg_pkg::*;
#(
	parameter int ADDR_W = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register access
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regWriteData,
	input wire logic [31:0] readData,
	input wire logic readHit,
	// datapath side
	input wire logic [15:0] rmsVoltage,
	input wire logic [15:0] rmsCurrent,
	input wire cfg_bank_t cfg,
	input wire logic [2:0] slotLineQuantity [8],
	input wire logic [7:0] slotConversionSkip,
	input wire logic [15:0] frameTimeTenthsUs,
	input wire logic [4:0] pulseOneSource,
	input wire elements_t pulseOneElements,
	input wire logic [4:0] pulseTwoSource,
	input wire elements_t pulseTwoElements,
	input wire scaled_t scaled
);
	// full-width products, so truncation is checked and not assumed
	logic [31:0] voltProd;
	logic [31:0] ampProd;
	logic [47:0] pwrProd;
	assign voltProd = 32'(cfg.voltageCal) * 32'(rmsVoltage);
	assign ampProd = 32'(cfg.currentCal) * 32'(rmsCurrent);
	assign pwrProd = 48'(cfg.powerCal) * 48'(rmsCurrent) * 48'(rmsVoltage);
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence readReq(a);
		regRead && regAddr == a;
	endsequence
	sequence refusedAnswer;
		!readHit && readData == 32'h0;
	endsequence
	hit_has_cause_a: assert property (readHit |-> $past(regRead)) else $error("hit without read");
	odd_read_refused_a: assert property (regRead && regAddr[0] |=> refusedAnswer) else $error("odd read answered");
	midword_refused_a: assert property (readReq(7'h2a) |=> refusedAnswer) else $error("mid-word read answered");
	frame_read_a: assert property (readReq(7'h20) |=> readHit && readData == {16'h0, $past(cfg.frameTimeCal)})
		else $error("frame word read wrong");
	read_hold_a: assert property (!regRead |=> $stable(readData)) else $error("read data moved");
	volt_write_a: assert property (regWrite && regAddr == 7'h22 |=> cfg.voltageCal == $past(regWriteData[15:0]))
		else $error("voltage word not written");
	slot_fields_a: assert property (slotLineQuantity[3] == cfg.scanSlot[3][3:1] && slotConversionSkip[3] == cfg.scanSlot[3][7])
		else $error("slot fields wrong");
	pulse_fields_a: assert property (pulseOneSource == cfg.pulseCfg[7:3] && pulseOneElements == cfg.pulseCfg[2:0]
		&& pulseTwoSource == cfg.pulseCfg[15:11] && pulseTwoElements == cfg.pulseCfg[10:8])
		else $error("pulse fields wrong");
	frame_out_a: assert property (frameTimeTenthsUs == cfg.frameTimeCal) else $error("frame time wrong");
	volt_scale_a: assert property (1'b1 |=> scaled.reportedVoltage == $past(voltProd) >> 16)
		else $error("voltage scale wrong");
	amp_scale_a: assert property (1'b1 |=> scaled.reportedCurrent == $past(ampProd) >> 16)
		else $error("current scale wrong");
	pwr_scale_a: assert property (1'b1 |=> scaled.reportedPower == 32'($past(pwrProd) >> 26))
		else $error("power scale wrong");
endmodule
bind metering_config_register_bank metering_config_register_bank_sva #(.ADDR_W(ADDR_W)) sva_u (.clk(clk),
	.rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
	.readData(readData), .readHit(readHit), .rmsVoltage(rmsVoltage), .rmsCurrent(rmsCurrent), .cfg(cfg),
	.slotLineQuantity(slotLineQuantity), .slotConversionSkip(slotConversionSkip),
	.frameTimeTenthsUs(frameTimeTenthsUs), .pulseOneSource(pulseOneSource), .pulseOneElements(pulseOneElements),
	.pulseTwoSource(pulseTwoSource), .pulseTwoElements(pulseTwoElements), .scaled(scaled));

// [bench/serial_master_model.sv]
/*
 * Behavioural serial-interface master: one-cycle read and write strobes.
 * Assumes the bank answers a read on the edge after it is taken.
 */
`timescale 1ns/1ps
module serial_master_model (
	// clock and answer
	input wire logic clk,
	input wire logic [31:0] readData,
	input wire logic readHit,
	// requests
	output logic [6:0] regAddr,
	output logic regWrite,
	output logic regRead,
	output logic [31:0] regWriteData
);
	initial begin
		regAddr = 7'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWriteData = 32'h0;
	end
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic [31:0] v;
		v = (a >= 7'h10 && a <= 7'h1c) ? (d & 32'h0ffe) : d;
		if (a != 7'h1e) begin
			@(posedge clk);
			regAddr <= a;
			regWriteData <= v;
			regWrite <= 1'b1;
			@(posedge clk);
			regWrite <= 1'b0;
			// released data shows junk, not the last value
			regWriteData <= ~v;
		end
	endtask
	task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic h);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		d = readData;
		h = readHit;
	endtask
endmodule

// [bench/metering_config_register_bank_bench.sv]
/*
 * Self-checking bench of the metering configuration bank.
 * Assumes the master model drives all register requests.
 */
`timescale 1ns/1ps
module metering_config_register_bank_bench;
	import meter_cfg_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] regAddr;
	logic regWrite;
	logic regRead;
	logic [31:0] regWriteData;
	logic [31:0] readData;
	logic readHit;
	logic [15:0] rmsVoltage = 16'h0;
	logic [15:0] rmsCurrent = 16'h0;
	cfg_bank_t cfg;
	logic [2:0] slotLineQuantity [8];
	logic [7:0] slotConversionSkip;
	logic [15:0] frameTimeTenthsUs;
	logic [4:0] pulseOneSource;
	elements_t pulseOneElements;
	logic [4:0] pulseTwoSource;
	elements_t pulseTwoElements;
	scaled_t scaled;
	int num_errors = 0;
	int cmp_count = 0;
	localparam logic [38:0] TBL [36] = '{{7'h10,32'h301}, {7'h12,32'h3}, {7'h14,32'h505}, {7'h16,32'h207},
		{7'h18,32'h409}, {7'h1a,32'h10b}, {7'h1c,32'h68d}, {7'h1e,32'h8af}, {7'h20,32'h7d0}, {7'h22,32'h81f0},
		{7'h24,32'h17d8}, {7'h26,32'h3539}, {7'h28,32'h841c2f}, {7'h2c,32'h11940000}, {7'h30,32'h1},
		{7'h32,32'h1707}, {7'h34,32'h19cd813}, {7'h38,32'h19cd813}, {7'h3c,32'h186a}, {7'h3e,32'h186a},
		{7'h54,32'h3000}, {7'h56,32'h5000}, {7'h58,32'h1000}, {7'h5a,32'h800}, {7'h5c,32'h1000},
		{7'h5e,32'h200}, {7'h60,32'h1000}, {7'h62,32'h301a}, {7'h6c,32'h32}, {7'h6e,32'h5}, {7'h70,32'h7fff},
		{7'h72,32'h7fff}, {7'h74,32'h0}, {7'h76,32'hffff}, {7'h78,32'hffff}, {7'h7a,32'h640}};
	always #4 clk = ~clk;
	metering_config_register_bank dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWriteData(regWriteData), .readData(readData), .readHit(readHit),
		.rmsVoltage(rmsVoltage), .rmsCurrent(rmsCurrent), .cfg(cfg), .slotLineQuantity(slotLineQuantity),
		.slotConversionSkip(slotConversionSkip), .frameTimeTenthsUs(frameTimeTenthsUs),
		.pulseOneSource(pulseOneSource), .pulseOneElements(pulseOneElements), .pulseTwoSource(pulseTwoSource),
		.pulseTwoElements(pulseTwoElements), .scaled(scaled));
	serial_master_model master_u (.clk(clk), .readData(readData), .readHit(readHit), .regAddr(regAddr),
		.regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData));
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [31:0] pattern(input int i);
		logic [6:0] a;
		logic [31:0] p;
		a = TBL[i][38:32];
		p = {8'(i), 8'h5a, 8'(~i), 8'hc3};
		if (a == 7'h1e)
			return TBL[i][31:0];
		if (a <= 7'h1c)
			return p & 32'h0ffe;
		return (a inside {7'h28, 7'h2c, 7'h34, 7'h38}) ? p : (p & 32'hffff);
	endfunction
	task automatic t_defaults();
		logic [31:0] d;
		logic h;
		for (int i = 0; i < 36; i++) begin
			master_u.rd(TBL[i][38:32], d, h);
			chk(d, TBL[i][31:0]);
			chk(32'(h), 32'h1);
		end
		$display("defaults done");
	endtask
	task automatic t_readback();
		logic [31:0] d;
		logic h;
		for (int i = 0; i < 36; i++)
			master_u.wr(TBL[i][38:32], pattern(i));
		for (int i = 0; i < 36; i++) begin
			master_u.rd(TBL[i][38:32], d, h);
			chk(d, pattern(i));
		end
		$display("readback done");
	endtask
	task automatic t_reset_again();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_defaults();
	endtask
	task automatic t_refused();
		logic [6:0] bad [6] = '{7'h40, 7'h53, 7'h64, 7'h2a, 7'h11, 7'h7c};
		logic [31:0] d;
		logic h;
		for (int i = 0; i < 6; i++) begin
			master_u.wr(bad[i], 32'hdead_beef);
			master_u.rd(bad[i], d, h);
			chk(d, 32'h0);
			chk(32'(h), 32'h0);
		end
		// a mid-word write must not touch the 32-bit word around it
		master_u.rd(7'h28, d, h);
		chk(d, 32'h00841c2f);
		$display("refused done");
	endtask
	task automatic t_fields();
		for (int q = 0; q < 7; q++) begin
			master_u.wr(7'h16, 32'((q << 1) | ((q & 1) << 7)));
			#1;
			chk(32'(slotLineQuantity[3]), 32'(q));
			chk(32'(slotConversionSkip[3]), 32'(q & 1));
		end
		master_u.wr(7'h32, 32'hb54e);
		master_u.wr(7'h20, 32'h0bb8);
		#1;
		chk({pulseTwoSource, pulseTwoElements, pulseOneSource, pulseOneElements}, 32'hb54e);
		chk(32'(pulseOneSource), 32'h09);
		chk(32'(pulseTwoElements), 32'h5);
		chk(32'(frameTimeTenthsUs), 32'h0bb8);
		$display("fields done");
	endtask
	task automatic t_scale();
		logic [15:0] v [2] = '{16'hfffe, 16'h0003};
		logic [15:0] c [2] = '{16'h1234, 16'hffff};
		logic [47:0] p;
		master_u.wr(7'h22, 32'hffff);
		master_u.wr(7'h24, 32'h8001);
		master_u.wr(7'h26, 32'hffff);
		for (int i = 0; i < 2; i++) begin
			// inputs change only on the rising edge
			@(posedge clk);
			rmsVoltage <= v[i];
			rmsCurrent <= c[i];
			repeat (3) @(posedge clk);
			#1;
			p = 48'hffff * 48'(c[i]) * 48'(v[i]);
			chk(32'(scaled.reportedVoltage), (32'hffff * 32'(v[i])) >> 16);
			chk(32'(scaled.reportedCurrent), (32'h8001 * 32'(c[i])) >> 16);
			chk(scaled.reportedPower, 32'(p >> 26));
		end
		$display("scale done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_defaults();
		t_readback();
		t_reset_again();
		t_refused();
		t_fields();
		t_scale();
		tally_and_finish();
	end
	initial begin
		#200us;
		num_errors++;
		tally_and_finish();
	end
endmodule
